/* include/spe_pkg.sv */
// Shared constants and types for the serial peripheral controller
package spe_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int WORD_W = 8;
   localparam int NUM_CS = 4;
   localparam int DIV_W = 8;
   localparam int CS_SEL_W = 2;
   localparam int BITCNT_W = 4;
   localparam int EDGE_W = 5;

   // ------------------------------------------------------------------
   // Reset values and fixed indices
   // ------------------------------------------------------------------
   localparam logic RST_TX_EMPTY = 1'h1;
   localparam logic RST_ENABLED = 1'h0;
   localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
   localparam logic [CS_SEL_W-1:0] HOLD_CHECK_CS = 2'h0;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [DIV_W-1:0] serial_clock_divider;
      logic clock_idle_polarity;
      logic clock_phase_inverted;
      logic hold_select_after_transfer;
   } spe_cs_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_MASTER = 3'h2,
      ST_SLAVE = 3'h4
   } spe_state_t;

endpackage

/* hdl/spe_shifter.sv */
// Master bit engine: serial clock generation and word shifting
`timescale 1ns/100ps
module spe_shifter #(
   parameter int WORD_W = 8,
   parameter int DIV_W = 8,
   parameter int EDGE_W = 5
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Request
   input wire logic start_in,
   input wire logic [DIV_W-1:0] div_in,
   input wire logic clock_idle_polarity_in,
   input wire logic clock_phase_inverted_in,
   input wire logic extra_in,
   input wire logic [WORD_W-1:0] tx_word_in,
   input wire logic miso_in,
   // Result and pins
   output logic busy_out,
   output logic done_out,
   output logic [WORD_W-1:0] rx_word_out,
   output logic sck_out,
   output logic mosi_out
);

   logic busy_reg, busy_next;
   logic done_reg, done_next;
   logic sck_reg, sck_next;
   logic extra_reg, extra_next;
   logic clock_phase_inverted_reg, clock_phase_inverted_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic [DIV_W-1:0] cnt_reg, cnt_next;
   logic [EDGE_W-1:0] edge_reg, edge_next;
   logic [WORD_W-1:0] sh_reg, sh_next;
   logic [WORD_W-1:0] rx_reg, rx_next;
   logic lead;

   localparam logic [EDGE_W-1:0] LAST_EDGE = EDGE_W'(2 * WORD_W - 1);

   always_comb begin
      busy_next = busy_reg;
      done_next = 1'b0;
      sck_next = sck_reg;
      extra_next = extra_reg;
      clock_phase_inverted_next = clock_phase_inverted_reg;
      div_next = div_reg;
      cnt_next = cnt_reg;
      edge_next = edge_reg;
      sh_next = sh_reg;
      rx_next = rx_reg;
      lead = ~edge_reg[0];
      if (!busy_reg) begin
         sck_next = clock_idle_polarity_in;
         if (start_in) begin
            busy_next = 1'b1;
            cnt_next = '0;
            edge_next = '0;
            extra_next = extra_in;
            clock_phase_inverted_next = clock_phase_inverted_in;
            sh_next = tx_word_in;
            // A zero divider would toggle only every 256 cycles, so it runs as one
            div_next = (div_in == '0) ? DIV_W'(1) : div_in;
         end
      end else if (cnt_reg == div_reg - DIV_W'(1)) begin
         cnt_next = '0;
         sck_next = ~sck_reg;
         if (extra_reg) begin
            // Stray pulse ahead of the data bits, nothing sampled
            edge_next = edge_reg[0] ? '0 : EDGE_W'(1);
            extra_next = ~edge_reg[0];
         end else begin
            if (clock_phase_inverted_reg ? lead : ~lead) begin
               rx_next = {rx_reg[WORD_W-2:0], miso_in};
            end else if (edge_reg != '0) begin
               sh_next = {sh_reg[WORD_W-2:0], 1'b0};
            end
            if (edge_reg == LAST_EDGE) begin
               busy_next = 1'b0;
               done_next = 1'b1;
            end
            edge_next = edge_reg + EDGE_W'(1);
         end
      end else begin
         cnt_next = cnt_reg + DIV_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         sck_reg <= 1'b0;
         extra_reg <= 1'b0;
         clock_phase_inverted_reg <= 1'b0;
         div_reg <= '0;
         cnt_reg <= '0;
         edge_reg <= '0;
         sh_reg <= '0;
         rx_reg <= '0;
      end else begin
         busy_reg <= busy_next;
         done_reg <= done_next;
         sck_reg <= sck_next;
         extra_reg <= extra_next;
         clock_phase_inverted_reg <= clock_phase_inverted_next;
         div_reg <= div_next;
         cnt_reg <= cnt_next;
         edge_reg <= edge_next;
         sh_reg <= sh_next;
         rx_reg <= rx_next;
      end
   end

   assign busy_out = busy_reg;
   assign done_out = done_reg;
   assign rx_word_out = rx_reg;
   assign sck_out = sck_reg;
   assign mosi_out = sh_reg[WORD_W-1];

endmodule // spe_shifter

/* hdl/spe_ctrl.sv */
// Serial peripheral controller, master and slave, with its known quirks
`timescale 1ns/100ps
module spe_ctrl #(
   parameter int WORD_W = spe_pkg::WORD_W,
   parameter int NUM_CS = spe_pkg::NUM_CS,
   parameter int DIV_W = spe_pkg::DIV_W
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Commands and configuration
   input wire logic enable_cmd_in,
   input wire logic disable_cmd_in,
   input wire logic soft_reset_bit_in,
   input wire logic master_mode_in,
   input wire logic fault_detect_disable_in,
   input wire logic [spe_pkg::CS_SEL_W-1:0] cs_sel_in,
   input wire logic [NUM_CS-1:0] cs_in_use_in,
   input wire spe_pkg::spe_cs_cfg_t [NUM_CS-1:0] chip_select_config_in,
   // Transmit write port, fed by software or the DMA channel
   input wire logic tx_wr_in,
   input wire logic [WORD_W-1:0] tx_data_in,
   // Receive read port
   input wire logic rx_read_in,
   // Status
   output logic enabled_out,
   output logic tx_empty_flag_out,
   output logic rx_full_out,
   output logic [WORD_W-1:0] rx_data_out,
   output logic busy_out,
   // Master pins
   output logic sck_out,
   output logic sck_oe_out,
   output logic mosi_out,
   output logic mosi_oe_out,
   output logic [NUM_CS-1:0] cs_n_out,
   input wire logic miso_in,
   // Slave pins
   input wire logic sck_in,
   input wire logic ss_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe_out
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic div_is_one(input logic [DIV_W-1:0] d);
      return d == spe_pkg::DIV_ONE;
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [3:0] meta_reg;
   logic [3:0] sync_reg;
   logic miso_s, sck_s, ss_n_s, mosi_s;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_reg <= 4'hF;
         sync_reg <= 4'hF;
      end else begin
         meta_reg <= {miso_in, sck_in, ss_n_in, mosi_in};
         sync_reg <= meta_reg;
      end
   end

   assign {miso_s, sck_s, ss_n_s, mosi_s} = sync_reg;

   // ------------------------------------------------------------------
   // Control state
   // ------------------------------------------------------------------
   spe_pkg::spe_state_t state_reg, state_next;
   logic enabled_reg, enabled_next;
   logic tx_empty_reg, tx_empty_next;
   logic [WORD_W-1:0] tx_data_reg, tx_data_next;
   logic rx_full_reg, rx_full_next;
   logic [WORD_W-1:0] rx_data_reg, rx_data_next;
   logic [NUM_CS-1:0] cs_n_reg, cs_n_next;
   logic [spe_pkg::CS_SEL_W-1:0] cur_cs_reg, cur_cs_next;
   logic sck_prev_reg, sck_prev_next;
   logic [spe_pkg::BITCNT_W-1:0] sl_cnt_reg, sl_cnt_next;
   logic [WORD_W-1:0] sl_sh_reg, sl_sh_next;
   logic [WORD_W-1:0] sl_rx_reg, sl_rx_next;

   spe_pkg::spe_cs_cfg_t sel_cfg, sl_cfg;
   logic any_one, any_other, extra_pulse, start_blocked, start;
   logic take_word, word_done, rx_load;
   logic [WORD_W-1:0] rx_word;
   logic sh_busy, sh_done;
   logic [WORD_W-1:0] sh_rx;
   logic sh_sck, sh_mosi;
   logic sl_edge, sl_lead, sl_sample, sl_shift;

   always_comb begin
      // Idle follows the requested select; a running word keeps its own
      sel_cfg = chip_select_config_in[(state_reg == spe_pkg::ST_IDLE) ? cs_sel_in : cur_cs_reg];
      sl_cfg = chip_select_config_in[0];
      any_one = 1'b0;
      any_other = 1'b0;
      for (int i = 0; i < NUM_CS; i++) begin
         if (cs_in_use_in[i]) begin
            if (div_is_one(chip_select_config_in[i].serial_clock_divider)) begin
               any_one = 1'b1;
            end else begin
               any_other = 1'b1;
            end
         end
      end
      // Quirk kept on purpose: mixed dividers with idle-high, leading-change mode
      extra_pulse = any_one && any_other && sel_cfg.clock_idle_polarity
                    && !sel_cfg.clock_phase_inverted;
      start_blocked = chip_select_config_in[spe_pkg::HOLD_CHECK_CS].hold_select_after_transfer
                      && !fault_detect_disable_in;

      state_next = state_reg;
      enabled_next = enabled_reg;
      tx_empty_next = tx_empty_reg;
      tx_data_next = tx_data_reg;
      rx_full_next = rx_full_reg;
      rx_data_next = rx_data_reg;
      cs_n_next = cs_n_reg;
      cur_cs_next = cur_cs_reg;
      sck_prev_next = sck_s;
      sl_cnt_next = sl_cnt_reg;
      sl_sh_next = sl_sh_reg;
      sl_rx_next = sl_rx_reg;
      start = 1'b0;
      take_word = 1'b0;
      rx_load = 1'b0;
      rx_word = sh_rx;
      word_done = 1'b0;

      // Slave clock edges seen through the synchroniser
      sl_edge = sck_s != sck_prev_reg;
      sl_lead = sl_edge && (sck_s != sl_cfg.clock_idle_polarity);
      sl_sample = sl_cfg.clock_phase_inverted ? sl_lead : (sl_edge && !sl_lead);
      sl_shift = sl_edge && !sl_sample;

      if (enable_cmd_in) begin
         enabled_next = 1'b1;
      end
      // Slave mode keeps running through a disable command
      if (disable_cmd_in && state_reg != spe_pkg::ST_SLAVE) begin
         enabled_next = 1'b0;
      end

      case (state_reg)
         spe_pkg::ST_IDLE: begin
            if (enabled_reg && !master_mode_in) begin
               state_next = spe_pkg::ST_SLAVE;
               cs_n_next = '1;
            end else if (enabled_reg && !tx_empty_reg && !start_blocked) begin
               cur_cs_next = cs_sel_in;
               start = 1'b1;
               take_word = 1'b1;
               cs_n_next = ~(NUM_CS'(1) << cs_sel_in);
               state_next = spe_pkg::ST_MASTER;
            end else if (!enabled_reg) begin
               cs_n_next = '1;
            end
         end
         spe_pkg::ST_MASTER: begin
            if (sh_done) begin
               rx_load = 1'b1;
               state_next = spe_pkg::ST_IDLE;
               if (!sel_cfg.hold_select_after_transfer) begin
                  cs_n_next = '1;
               end
            end
         end
         spe_pkg::ST_SLAVE: begin
            if (ss_n_s) begin
               sl_cnt_next = '0;
               if (!tx_empty_reg && sl_cnt_reg == '0) begin
                  take_word = 1'b1;
                  sl_sh_next = tx_data_reg;
               end
            end else if (sl_sample) begin
               sl_rx_next = {sl_rx_reg[WORD_W-2:0], mosi_s};
               if (sl_cnt_reg == spe_pkg::BITCNT_W'(WORD_W - 1)) begin
                  word_done = 1'b1;
                  sl_cnt_next = '0;
               end else begin
                  sl_cnt_next = sl_cnt_reg + spe_pkg::BITCNT_W'(1);
               end
            end else if (sl_shift && sl_cnt_reg != '0) begin
               sl_sh_next = {sl_sh_reg[WORD_W-2:0], 1'b0};
            end
            if (word_done) begin
               rx_load = 1'b1;
               rx_word = {sl_rx_reg[WORD_W-2:0], mosi_s};
               if (!tx_empty_reg) begin
                  take_word = 1'b1;
                  sl_sh_next = tx_data_reg;
               end
            end
         end
         default: begin
            state_next = spe_pkg::ST_IDLE;
         end
      endcase

      // Holding register: a load frees it, an accepted write fills it
      if (take_word) begin
         tx_empty_next = 1'b1;
      end
      // Writes are filtered while disabled; the flag is left as it stands
      // A DMA still feeding after a disable sees the flag high and loses words
      if (tx_wr_in && enabled_reg) begin
         tx_data_next = tx_data_in;
         tx_empty_next = 1'b0;
      end

      if (rx_read_in) begin
         rx_full_next = 1'b0;
      end
      if (rx_load) begin
         rx_full_next = 1'b1;
         rx_data_next = rx_word;
      end

      // Soft reset and arst_n_in are the only ways out of slave mode
      if (soft_reset_bit_in) begin
         state_next = spe_pkg::ST_IDLE;
         enabled_next = spe_pkg::RST_ENABLED;
         tx_empty_next = spe_pkg::RST_TX_EMPTY;
         rx_full_next = 1'b0;
         rx_data_next = '0;
         cs_n_next = '1;
         sl_cnt_next = '0;
         sl_sh_next = '0;
         sl_rx_next = '0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= spe_pkg::ST_IDLE;
         enabled_reg <= spe_pkg::RST_ENABLED;
         tx_empty_reg <= spe_pkg::RST_TX_EMPTY;
         tx_data_reg <= '0;
         rx_full_reg <= 1'b0;
         rx_data_reg <= '0;
         cs_n_reg <= '1;
         cur_cs_reg <= '0;
         sck_prev_reg <= 1'b1;
         sl_cnt_reg <= '0;
         sl_sh_reg <= '0;
         sl_rx_reg <= '0;
      end else begin
         state_reg <= state_next;
         enabled_reg <= enabled_next;
         tx_empty_reg <= tx_empty_next;
         tx_data_reg <= tx_data_next;
         rx_full_reg <= rx_full_next;
         rx_data_reg <= rx_data_next;
         cs_n_reg <= cs_n_next;
         cur_cs_reg <= cur_cs_next;
         sck_prev_reg <= sck_prev_next;
         sl_cnt_reg <= sl_cnt_next;
         sl_sh_reg <= sl_sh_next;
         sl_rx_reg <= sl_rx_next;
      end
   end

   // ------------------------------------------------------------------
   // Master bit engine
   // ------------------------------------------------------------------
   spe_shifter #(
      .WORD_W(WORD_W),
      .DIV_W(DIV_W),
      .EDGE_W(spe_pkg::EDGE_W)
   ) u_shifter (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .start_in(start),
      .div_in(sel_cfg.serial_clock_divider),
      .clock_idle_polarity_in(sel_cfg.clock_idle_polarity),
      .clock_phase_inverted_in(sel_cfg.clock_phase_inverted),
      .extra_in(extra_pulse),
      .tx_word_in(tx_data_reg),
      .miso_in(miso_s),
      .busy_out(sh_busy),
      .done_out(sh_done),
      .rx_word_out(sh_rx),
      .sck_out(sh_sck),
      .mosi_out(sh_mosi)
   );

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign enabled_out = enabled_reg;
   assign tx_empty_flag_out = tx_empty_reg;
   assign rx_full_out = rx_full_reg;
   assign rx_data_out = rx_data_reg;
   assign busy_out = sh_busy || (state_reg == spe_pkg::ST_SLAVE && sl_cnt_reg != '0);
   assign sck_out = sh_sck;
   assign sck_oe_out = master_mode_in && state_reg != spe_pkg::ST_SLAVE;
   assign mosi_out = sh_mosi;
   assign mosi_oe_out = sck_oe_out;
   assign cs_n_out = cs_n_reg;
   assign miso_out = sl_sh_reg[WORD_W-1];
   assign miso_oe_out = state_reg == spe_pkg::ST_SLAVE && !ss_n_s;

endmodule // spe_ctrl

/* testbench/spe_ctrl_chk.sv */
// Concurrent checks on the ports of the serial peripheral controller
`timescale 1ns/100ps
module spe_ctrl_chk #(
   parameter int WORD_W = 8,
   parameter int NUM_CS = 4,
   parameter int DIV_W = 8
) (
   // Clock, reset and controls
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic disable_cmd_in,
   input wire logic soft_reset_bit_in,
   input wire logic fault_detect_disable_in,
   input wire logic [spe_pkg::CS_SEL_W-1:0] cs_sel_in,
   input wire logic [NUM_CS-1:0] cs_in_use_in,
   input wire spe_pkg::spe_cs_cfg_t [NUM_CS-1:0] chip_select_config_in,
   input wire logic tx_wr_in,
   // Observed outputs
   input wire logic enabled_out,
   input wire logic tx_empty_flag_out,
   input wire logic rx_full_out,
   input wire logic busy_out,
   input wire logic sck_out,
   input wire logic sck_oe_out,
   input wire logic [NUM_CS-1:0] cs_n_out,
   input wire logic miso_oe_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   // --------------------------------------------------------------
   // Serial clock edge count within one select window
   // --------------------------------------------------------------
   logic [5:0] edge_cnt_reg, edge_cnt_next;
   logic sck_reg, has_one, has_other, extra;
   always_comb begin
      has_one = 1'h0;
      has_other = 1'h0;
      for (int i = 0; i < NUM_CS; i++) begin
         if (cs_in_use_in[i] && chip_select_config_in[i].serial_clock_divider == spe_pkg::DIV_ONE)
            has_one = 1'h1;
         else if (cs_in_use_in[i])
            has_other = 1'h1;
      end
      extra = has_one && has_other && chip_select_config_in[cs_sel_in].clock_idle_polarity
         && !chip_select_config_in[cs_sel_in].clock_phase_inverted;
      edge_cnt_next = edge_cnt_reg;
      if (&cs_n_out)
         edge_cnt_next = 6'h00;
      else if (sck_oe_out && sck_out != sck_reg)
         edge_cnt_next = edge_cnt_reg + 6'h01;
   end
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         edge_cnt_reg <= 6'h00;
         sck_reg <= 1'h0;
      end else begin
         edge_cnt_reg <= edge_cnt_next;
         sck_reg <= sck_out;
      end
   end
   dis_slave_a: assert property (disable_cmd_in && miso_oe_out && !soft_reset_bit_in
      |=> enabled_out) else $error("disable stopped a slave");
   srst_idle_a: assert property (soft_reset_bit_in
      |=> !enabled_out && tx_empty_flag_out && !rx_full_out && &cs_n_out)
      else $error("soft reset did not idle");
   wr_drop_a: assert property (tx_wr_in && !enabled_out && tx_empty_flag_out
      |=> tx_empty_flag_out) else $error("write taken while disabled");
   dis_keep_a: assert property (disable_cmd_in && tx_empty_flag_out && !soft_reset_bit_in
      && !tx_wr_in |=> tx_empty_flag_out) else $error("disable changed empty flag");
   wr_clear_a: assert property (tx_wr_in && enabled_out && !soft_reset_bit_in
      |=> !tx_empty_flag_out) else $error("write did not clear empty flag");
   hold_block_a: assert property (!fault_detect_disable_in && &cs_n_out
      && chip_select_config_in[0].hold_select_after_transfer |=> &cs_n_out)
      else $error("transfer started with hold and fault detection");
   start_cs_a: assert property (enabled_out && sck_oe_out && !busy_out && !tx_empty_flag_out
      && &cs_n_out && !tx_wr_in && !disable_cmd_in && !soft_reset_bit_in
      && (fault_detect_disable_in || !chip_select_config_in[0].hold_select_after_transfer)
      |=> !cs_n_out[$past(cs_sel_in)] && tx_empty_flag_out) else $error("waiting word not started");
   edge_count_a: assert property ($rose(rx_full_out) && sck_oe_out
      |-> edge_cnt_reg == (extra ? 6'h12 : 6'h10)) else $error("wrong serial clock edge count");
   cover property ($rose(rx_full_out) && sck_oe_out && extra);
   cover property (disable_cmd_in && miso_oe_out);
   cover property (!fault_detect_disable_in && tx_wr_in && enabled_out);
endmodule // spe_ctrl_chk

bind spe_ctrl spe_ctrl_chk #(.WORD_W(WORD_W), .NUM_CS(NUM_CS), .DIV_W(DIV_W)) u_chk (.*);

/* testbench/spe_slave_model.sv */
// Behavioural external slave device on the master pins
`timescale 1ns/100ps
module spe_slave_model #(
   parameter time DLY = 3ns
) (
   // Serial pins and selected mode
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic sel_n_in,
   input wire logic clock_idle_polarity_in,
   input wire logic clock_phase_inverted_in,
   input wire logic [7:0] tx_byte_in,
   output logic miso_out,
   output logic [7:0] rx_byte_out
);
   logic [7:0] sh = 8'h00;
   logic skip = 1'h0;
   initial miso_out = 1'h0;
   initial rx_byte_out = 8'h00;
   always @(negedge sel_n_in) begin
      sh = tx_byte_in;
      skip = !clock_phase_inverted_in;
      miso_out <= #DLY sh[7];
   end
   // Released line shows no stale bit
   always @(posedge sel_n_in) miso_out <= #DLY ~miso_out;
   always @(sck_in) begin
      if (!sel_n_in && ((sck_in != clock_idle_polarity_in) == clock_phase_inverted_in))
         rx_byte_out = {rx_byte_out[6:0], mosi_in};
      else if (!sel_n_in && skip)
         skip = 1'h0;
      else if (!sel_n_in) begin
         sh = {sh[6:0], 1'h0};
         miso_out <= #DLY sh[7];
      end
   end
endmodule // spe_slave_model

/* testbench/spe_ctrl_tb.sv */
// Self-checking bench for the serial peripheral controller
`timescale 1ns/100ps
module spe_ctrl_tb;
   logic ref_clk_in = 0, arst_n_in = 0, enable_cmd_in = 0, disable_cmd_in = 0;
   logic soft_reset_bit_in = 0, master_mode_in = 1, fault_detect_disable_in = 1;
   logic tx_wr_in = 0, rx_read_in = 0, sck_in = 0, ss_n_in = 1, mosi_in = 0, miso_in;
   logic [1:0] cs_sel_in = 2'h1;
   logic [3:0] cs_in_use_in = 4'h2, cs_n_out;
   logic [7:0] tx_data_in = 8'h00, rx_data_out, slv_tx = 8'h00, slv_rx, d;
   spe_pkg::spe_cs_cfg_t [3:0] chip_select_config_in;
   logic enabled_out, tx_empty_flag_out, rx_full_out, busy_out, sck_out, sck_oe_out;
   logic mosi_out, mosi_oe_out, miso_out, miso_oe_out;
   int mismatches = 0, n_checks = 0, cyc = 0;
   logic [8:0] exp_q[$];
   always #12.5 ref_clk_in = ~ref_clk_in;
   spe_ctrl DUT (.*);
   spe_slave_model u_slv (.sck_in(sck_out), .mosi_in(mosi_out), .sel_n_in(cs_n_out[cs_sel_in]),
      .clock_idle_polarity_in(chip_select_config_in[cs_sel_in].clock_idle_polarity),
      .clock_phase_inverted_in(chip_select_config_in[cs_sel_in].clock_phase_inverted),
      .tx_byte_in(slv_tx), .miso_out(miso_in), .rx_byte_out(slv_rx));
   task automatic check_word(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp, input string what);
      check_word({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic cmd(input int k);
      @(negedge ref_clk_in);
      {soft_reset_bit_in, disable_cmd_in, enable_cmd_in} = 3'h1 << k;
      @(negedge ref_clk_in);
      {soft_reset_bit_in, disable_cmd_in, enable_cmd_in} = 3'h0;
   endtask
   task automatic wr(input logic [7:0] v);
      @(negedge ref_clk_in);
      tx_wr_in = 1;
      tx_data_in = v;
      @(negedge ref_clk_in);
      tx_wr_in = 0;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 300 && !(&cs_n_out && tx_empty_flag_out && !busy_out); i++) cyc_n(1);
      cyc_n(3);
   endtask
   // --------------------------------------------------------------
   // Result monitor: each received word is read, and compared unless its note has bit 8 set
   // --------------------------------------------------------------
   always @(negedge ref_clk_in) begin
      rx_read_in <= 0;
      if (rx_full_out === 1'h1 && !rx_read_in) begin
         rx_read_in <= 1;
         if (exp_q.size() == 0)
            check_bit(1'h1, 1'h0, "word without note");
         else if (!exp_q[0][8])
            check_word(rx_data_out, exp_q[0][7:0], "received word");
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
   end
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         $display("unexpected at %0t: timeout", $time);
         give_verdict();
      end
   end
   initial begin
      void'($urandom(27481));
      for (int i = 0; i < 4; i++) chip_select_config_in[i] = '{8'h04, 1'h0, 1'h1, 1'h0};
      cyc_n(20);
      arst_n_in = 1;
      cyc_n(1);
      check_bit(tx_empty_flag_out, 1'h1, "flag after reset");
      wr($urandom);
      cyc_n(3);
      check_bit(tx_empty_flag_out, 1'h1, "write while disabled");
      check_bit(&cs_n_out, 1'h1, "start while disabled");
      cmd(0);
      for (int m = 0; m < 4; m++) begin
         {chip_select_config_in[1].clock_idle_polarity,
          chip_select_config_in[1].clock_phase_inverted} = m[1:0];
         slv_tx = $urandom;
         wr($urandom);
         check_bit(tx_empty_flag_out, 1'h0, "flag after write");
         exp_q.push_back({1'h0, slv_tx});
         for (int i = 0; i < 50 && !tx_empty_flag_out; i++) cyc_n(1);
         d = $urandom;
         wr(d);
         exp_q.push_back({1'h0, slv_tx});
         wait_idle();
         check_word(slv_rx, d, "word at far side");
      end
      // Mixed, then matched dividers, idle-high, phase cleared: edge count left to the checker
      cs_in_use_in = 4'h3;
      chip_select_config_in[0] = '{8'h01, 1'h1, 1'h0, 1'h0};
      chip_select_config_in[1] = '{8'h04, 1'h1, 1'h0, 1'h0};
      for (int s = 1; s >= 0; s--) begin
         cs_sel_in = s[1:0];
         exp_q.push_back(9'h100);
         wr($urandom);
         wait_idle();
      end
      chip_select_config_in[1].serial_clock_divider = 8'h01;
      cs_sel_in = 2'h1;
      exp_q.push_back(9'h100);
      wr($urandom);
      wait_idle();
      cs_in_use_in = 4'h2;
      chip_select_config_in[1] = '{8'h04, 1'h0, 1'h1, 1'h0};
      chip_select_config_in[0].hold_select_after_transfer = 1;
      fault_detect_disable_in = 0;
      wr($urandom);
      cyc_n(60);
      check_bit(&cs_n_out, 1'h1, "start with hold and fault detection");
      check_bit(tx_empty_flag_out, 1'h0, "blocked word kept");
      cmd(2);
      check_bit(enabled_out, 1'h0, "soft reset disables");
      chip_select_config_in[0].hold_select_after_transfer = 0;
      fault_detect_disable_in = 1;
      cmd(0);
      exp_q.push_back({1'h0, slv_tx});
      wr($urandom);
      cyc_n(2);
      cmd(1);
      for (int i = 0; i < 3; i++) begin
         wr($urandom);
         check_bit(tx_empty_flag_out, 1'h1, "flag after disable");
      end
      wait_idle();
      check_bit(&cs_n_out, 1'h1, "lost words stay lost");
      master_mode_in = 0;
      cmd(2);
      cmd(0);
      d = $urandom;
      exp_q.push_back({1'h0, d});
      slv_tx = $urandom;
      wr(slv_tx);
      cyc_n(2);
      check_bit(tx_empty_flag_out, 1'h1, "slave load frees holding register");
      ss_n_in = 0;
      cyc_n(4);
      for (int b = 7; b >= 0; b--) begin
         mosi_in = d[b];
         cyc_n(4);
         check_bit(miso_out, slv_tx[b], "slave transmit bit");
         sck_in = 1;
         cyc_n(4);
         sck_in = 0;
      end
      cyc_n(6);
      cmd(1);
      check_bit(enabled_out, 1'h1, "slave ignores disable");
      check_bit(mosi_oe_out, 1'h0, "master pins driven in slave");
      ss_n_in = 1;
      mosi_in = ~mosi_in;
      cmd(2);
      check_bit(enabled_out, 1'h0, "soft reset leaves slave");
      master_mode_in = 1;
      cyc_n(5);
      check_bit(exp_q.size() == 0, 1'h1, "words missing");
      give_verdict();
   end
endmodule // spe_ctrl_tb
